// file: hw/pen_touch_defs.svh
// constant definitions for the pen touch request logic
`ifndef PEN_TOUCH_DEFS_SVH
`define PEN_TOUCH_DEFS_SVH

// ==========================================
// register byte offsets
`define PT_OFF_CTRL    8'h00
`define PT_OFF_STATUS  8'h04
`define PT_OFF_MASK    8'h08
`define PT_OFF_STATE   8'h0C

// ==========================================
// field positions
`define PT_CTRL_ENABLE_BIT   0
`define PT_EV_REQUEST_BIT    0
`define PT_EV_START_BIT      1
`define PT_EV_COMMIT_BIT     2
`define PT_EV_CONV_BIT       3
`define PT_EV_WIDTH          4

// ==========================================
// reset values and the all-on power-down code
`define PT_CTRL_RESET  32'h0000_0001
`define PT_MASK_RESET  4'h0
`define PT_PD_RESET    2'h0
`define PT_PD_ALL_ON   2'h3

// ==========================================
// serial clock counts
`define PT_RELEASE_FALLS  4'h4
`define PT_COMMIT_FALLS   4'h8
`define PT_WORD_RISES     4'h8

`endif

// file: hw/pen_touch_pkg.sv
// types shared by the pen touch request logic
package pen_touch_pkg;

  // ==========================================
  // control word reception phases
  typedef enum logic [1:0] {
    phase_idle,
    phase_shift,
    phase_acq
  } word_phase_t;

endpackage

// file: hw/pin_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps

module pin_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_sync_out
);

  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  // ==========================================
  // stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 4'h0;
      stage2_reg <= 4'h0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign pin_sync_out = stage2_reg;

endmodule // pin_sync

// file: hw/pen_touch_request.sv
// pen touch request logic with control word tracking and apb registers
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "pen_touch_defs.svh"

// Behaviour
// - request pin released high whenever no enabled touch is signalled and no start-bit hold is active
// - armed function plus touch pulls request pin low
// - function stays armed while powered down between conversions
// - function is armed after reset, before any control word
// - start bit disarms the touch function
// - low request held until fourth falling serial clock after start
// - that release never re-arms; only loaded power-down bits do
// - newly armed function responds only after conversion completes
// - overlapped start bit disarms again before conversion end
// - first conversion after power-up is valid, none discarded
// - control word accepted only after start, bits on first eight rises
// - power bits updated only after acquisition, at conversion start
// - power-down bits both one keep the function disarmed
module pen_touch_request (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        touch_sensed,
  input  wire logic        serial_shift_clock,
  input  wire logic        serial_data_in,
  input  wire logic        chip_select_n,
  input  wire logic        conversion_complete,
  output logic             pen_touch_request_n,
  output logic             pen_touch_request_oe,
  output logic [1:0]       power_down_select_bits,
  output logic             result_valid
);

  // ==========================================
  // pin synchronisation
  logic [3:0] pins_s;
  logic       touch_s;
  logic       sclk_s;
  logic       din_s;
  logic       cs_n_s;
  logic       sclk_d_reg;
  logic       sclk_rise;
  logic       sclk_fall;

  pin_sync u_pin_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       ({chip_select_n, serial_data_in, serial_shift_clock, touch_sensed}),
    .pin_sync_out (pins_s)
  );

  assign touch_s   = pins_s[0];
  assign sclk_s    = pins_s[1];
  assign din_s     = pins_s[2];
  assign cs_n_s    = pins_s[3];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;

  // ==========================================
  // helpers
  function automatic logic pd_arms(input logic [1:0] pd);
    pd_arms = (pd != `PT_PD_ALL_ON);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `PT_OFF_CTRL) || (addr == `PT_OFF_STATUS) ||
                (addr == `PT_OFF_MASK) || (addr == `PT_OFF_STATE);
  endfunction

  // ==========================================
  // control word tracking and arming
  pen_touch_pkg::word_phase_t phase_reg, phase_next;
  logic [3:0] rise_cnt_reg, rise_cnt_next;
  logic [3:0] fall_cnt_reg, fall_cnt_next;
  logic [7:0] word_reg, word_next;
  logic [1:0] pd_reg, pd_next;
  logic       armed_reg, armed_next;
  logic       pend_reg, pend_next;
  logic       hold_reg, hold_next;
  logic       drive_reg, drive_next;
  logic       pin_n_reg, pin_n_next;
  logic       valid_reg, valid_next;
  logic       start_det;
  logic       commit;
  logic       sw_enable;

  always_comb begin
    phase_next    = phase_reg;
    rise_cnt_next = rise_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    word_next     = word_reg;
    pd_next       = pd_reg;
    armed_next    = armed_reg;
    pend_next     = pend_reg;
    hold_next     = hold_reg;
    start_det     = 1'b0;
    commit        = 1'b0;
    if (cs_n_s) begin
      // deselect aborts the word; a stopped clock must not strand the pin low
      phase_next = pen_touch_pkg::phase_idle;
      hold_next  = 1'b0;
    end else begin
      case (phase_reg)
        pen_touch_pkg::phase_idle: begin
          if (sclk_rise && din_s) begin
            start_det     = 1'b1;
            phase_next    = pen_touch_pkg::phase_shift;
            rise_cnt_next = 4'h1;
            fall_cnt_next = 4'h0;
            word_next     = 8'h01;
          end
        end
        pen_touch_pkg::phase_shift: begin
          if (sclk_rise) begin
            word_next     = {word_reg[6:0], din_s};
            rise_cnt_next = rise_cnt_reg + 4'h1;
            if (rise_cnt_reg == `PT_WORD_RISES - 4'h1) begin
              phase_next = pen_touch_pkg::phase_acq;
            end
          end
          if (sclk_fall) begin
            fall_cnt_next = fall_cnt_reg + 4'h1;
          end
        end
        pen_touch_pkg::phase_acq: begin
          if (sclk_fall) begin
            fall_cnt_next = fall_cnt_reg + 4'h1;
            if (fall_cnt_reg == `PT_COMMIT_FALLS - 4'h1) begin
              commit     = 1'b1;
              phase_next = pen_touch_pkg::phase_idle;
              pd_next    = word_reg[1:0];
              pend_next  = pd_arms(word_reg[1:0]);
            end
          end
        end
        default: phase_next = pen_touch_pkg::phase_idle;
      endcase
      if (sclk_fall && phase_reg != pen_touch_pkg::phase_idle &&
          fall_cnt_reg == `PT_RELEASE_FALLS - 4'h1) begin
        hold_next = 1'b0;
      end
    end
    if (start_det) begin
      armed_next = 1'b0;
      pend_next  = 1'b0;
      hold_next  = drive_reg;
    end else if (conversion_complete && pend_reg) begin
      armed_next = 1'b1;
      pend_next  = 1'b0;
    end
    drive_next = (armed_next & touch_s & sw_enable) | hold_next;
    pin_n_next = ~drive_next;
    valid_next = conversion_complete;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg    <= pen_touch_pkg::phase_idle;
      rise_cnt_reg <= 4'h0;
      fall_cnt_reg <= 4'h0;
      word_reg     <= 8'h00;
      pd_reg       <= `PT_PD_RESET;
      armed_reg    <= 1'b1;
      pend_reg     <= 1'b0;
      hold_reg     <= 1'b0;
      drive_reg    <= 1'b0;
      pin_n_reg    <= 1'b1;
      valid_reg    <= 1'b0;
      sclk_d_reg   <= 1'b0;
    end else begin
      phase_reg    <= phase_next;
      rise_cnt_reg <= rise_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      word_reg     <= word_next;
      pd_reg       <= pd_next;
      armed_reg    <= armed_next;
      pend_reg     <= pend_next;
      hold_reg     <= hold_next;
      drive_reg    <= drive_next;
      pin_n_reg    <= pin_n_next;
      valid_reg    <= valid_next;
      sclk_d_reg   <= sclk_s;
    end
  end

  assign pen_touch_request_oe   = drive_reg;
  assign pen_touch_request_n    = pin_n_reg;
  assign power_down_select_bits = pd_reg;
  assign result_valid           = valid_reg;

  // ==========================================
  // apb registers and interrupt
  logic [31:0]                 ctrl_reg, ctrl_next;
  logic [`PT_EV_WIDTH-1:0]     status_reg, status_next;
  logic [`PT_EV_WIDTH-1:0]     mask_reg, mask_next;
  logic [`PT_EV_WIDTH-1:0]     events;
  logic [31:0]                 prdata_reg, prdata_next;
  logic                        pready_reg, pready_next;
  logic                        pslverr_reg, pslverr_next;
  logic                        irq_reg, irq_next;
  logic                        access_end;
  logic                        mapped;

  assign sw_enable  = ctrl_reg[`PT_CTRL_ENABLE_BIT];
  assign access_end = psel & penable & pready_reg;
  assign mapped     = is_mapped(paddr);

  always_comb begin
    events                      = '0;
    events[`PT_EV_REQUEST_BIT]  = drive_next & ~drive_reg;
    events[`PT_EV_START_BIT]    = start_det;
    events[`PT_EV_COMMIT_BIT]   = commit;
    events[`PT_EV_CONV_BIT]     = conversion_complete;
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    status_next  = status_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel & penable & ~pready_reg; // one wait state
    pslverr_next = psel & penable & ~pready_reg & ~mapped;
    if (psel && penable && !pready_reg && !pwrite) begin
      case (paddr)
        `PT_OFF_CTRL:   prdata_next = ctrl_reg;
        `PT_OFF_STATUS: prdata_next = {28'h0000000, status_reg};
        `PT_OFF_MASK:   prdata_next = {28'h0000000, mask_reg};
        `PT_OFF_STATE:  prdata_next = {24'h000000, pd_reg, drive_reg, hold_reg, pend_reg, armed_reg,
                                       phase_reg};
        default:        prdata_next = 32'h0000_0000;
      endcase
    end
    if (access_end && pwrite && mapped) begin
      if (paddr == `PT_OFF_CTRL) ctrl_next = {31'h00000000, pwdata[`PT_CTRL_ENABLE_BIT]};
      if (paddr == `PT_OFF_MASK) mask_next = pwdata[`PT_EV_WIDTH-1:0];
    end
    if (access_end && !pwrite && paddr == `PT_OFF_STATUS) begin
      status_next = '0;
    end
    // a new event outranks the read clear
    status_next = status_next | events;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= `PT_CTRL_RESET;
      status_reg  <= '0;
      mask_reg    <= `PT_MASK_RESET;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic word_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) word_seen_reg <= 1'b0;
    else if (start_det) word_seen_reg <= 1'b1;
  end

  sequence start_while_low;
    start_det && drive_reg;
  endsequence

  sequence fourth_fall;
    sclk_fall && !cs_n_s && phase_reg != pen_touch_pkg::phase_idle && fall_cnt_reg == 4'h3;
  endsequence

  chk_idle_released: assert property (!armed_next && !hold_next |=> !pen_touch_request_oe && pen_touch_request_n)
    else $error("request pin driven with function disarmed and no hold");
  chk_touch_drives: assert property (armed_reg && touch_s && sw_enable && !start_det |=> pen_touch_request_oe)
    else $error("armed touch did not pull request low");
  chk_arm_kept: assert property (armed_reg && !start_det |=> armed_reg)
    else $error("armed function dropped without start bit");
  chk_armed_reset: assert property (!word_seen_reg |-> armed_reg)
    else $error("function not armed before first control word");
  chk_start_disarms: assert property (start_det |=> !armed_reg && !pend_reg)
    else $error("start bit did not disarm function");
  chk_hold_release: assert property (start_while_low |=> hold_reg && pen_touch_request_oe)
    else $error("low request not held after start bit");
  chk_fourth_fall: assert property (fourth_fall |=> !hold_reg)
    else $error("hold not released on fourth falling edge");
  chk_no_rearm: assert property ($fell(hold_reg) |-> !armed_reg)
    else $error("release of hold re-armed the function");
  chk_arm_on_done: assert property ($rose(armed_reg) |-> $past(conversion_complete) && $past(pend_reg))
    else $error("function re-armed before conversion completed");
  chk_first_valid: assert property (conversion_complete |=> result_valid)
    else $error("conversion result not flagged valid");
  chk_word_after_start: assert property ($rose(phase_reg == pen_touch_pkg::phase_shift) |-> $past(start_det))
    else $error("control word taken without start bit");
  chk_pd_commit: assert property ($changed(pd_reg) |-> $past(commit))
    else $error("power bits changed outside conversion start");
  chk_all_on_off: assert property (commit && word_reg[1:0] == 2'h3 |=> !pend_reg ##1 !armed_reg)
    else $error("all-on power setting armed the function");

endmodule // pen_touch_request

// file: testbench/host_serial_model.sv
// host side model: sends control words over the serial port
`timescale 1ns/1ps

module host_serial_model #(
  parameter int HALF = 6
) (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] word,
  output logic            serial_shift_clock,
  output logic            serial_data_in,
  output logic            chip_select_n,
  output logic      [3:0] fall_count,
  output logic            busy
);
  // ==========================================
  // word sender
  // one process owns every output, so each has a single driver
  // clock stands low between words; select stays low so words can overlap
  initial begin
    serial_shift_clock = 1'b0;
    serial_data_in     = 1'b0;
    chip_select_n      = 1'b1;
    fall_count         = 4'h0;
    busy               = 1'b0;
    forever begin
      @(posedge pclk);
      if (go && !busy) begin
        busy          <= 1'b1;
        fall_count    <= 4'h0;
        chip_select_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
          serial_data_in <= word[7 - i];
          repeat (HALF) @(posedge pclk);
          serial_shift_clock <= 1'b1;
          repeat (HALF) @(posedge pclk);
          serial_shift_clock <= 1'b0;
          fall_count         <= fall_count + 4'h1;
        end
        // released data line must not keep showing the last bit
        serial_data_in <= ~word[0];
        busy           <= 1'b0;
      end
    end
  end
endmodule // host_serial_model

// file: testbench/pen_touch_request_tb.sv
// self-checking bench for the pen touch request logic
`timescale 1ns/1ps
`include "pen_touch_defs.svh"

`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
`define WAIT_UNTIL(cond, lim) begin n = 0; while (!(cond) && n < (lim)) begin @(posedge pclk); n++; end \
  if (!(cond)) begin num_errors++; $display("MISMATCH at %0t: got %h expected %h", $time, n, (lim)); end end

module pen_touch_request_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        touch_sensed, serial_shift_clock, serial_data_in, chip_select_n, conversion_complete;
  logic        pen_touch_request_n, pen_touch_request_oe, result_valid, go, busy, er, bad, pen_wire;
  logic [1:0]  power_down_select_bits;
  logic [7:0]  word;
  logic [3:0]  fall_count;
  int          n;
  int          cycles = 0;
  int          num_errors = 0;
  int          tests_run = 0;

  // pull-up gives the idle level whenever the pin is not driven
  assign pen_wire = pen_touch_request_oe ? 1'b0 : 1'b1;

  pen_touch_request uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .touch_sensed(touch_sensed), .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
    .chip_select_n(chip_select_n), .conversion_complete(conversion_complete),
    .pen_touch_request_n(pen_touch_request_n), .pen_touch_request_oe(pen_touch_request_oe),
    .power_down_select_bits(power_down_select_bits), .result_valid(result_valid)
  );

  host_serial_model host (
    .pclk(pclk), .go(go), .word(word), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .chip_select_n(chip_select_n), .fall_count(fall_count), .busy(busy)
  );

  // ==========================================
  // clock, timeout and closing
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  // ==========================================
  // access tasks
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed: only the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send_word(input logic [7:0] w);
    word <= w;
    go   <= 1'b1;
    `WAIT_UNTIL(busy === 1'b1, 4)
    go <= 1'b0;
  endtask

  task automatic conv_done();
    conversion_complete <= 1'b1;
    @(posedge pclk);
    conversion_complete <= 1'b0;
    @(negedge pclk);
    `CHECK(result_valid, 1'b1)
    @(posedge pclk);
  endtask

  // ==========================================
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    touch_sensed = 1'b0;
    conversion_complete = 1'b0;
    go = 1'b0;
    word = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHECK(pen_wire, 1'b1)
    `CHECK(power_down_select_bits, `PT_PD_RESET)
    apb_xfer(1'b0, `PT_OFF_STATE, 32'h0);
    `CHECK(rd, 32'h0000_0004)
    apb_xfer(1'b0, `PT_OFF_CTRL, 32'h0);
    `CHECK(rd, `PT_CTRL_RESET)
    apb_xfer(1'b0, 8'h10, 32'h0);
    `CHECK({er, rd}, {1'b1, 32'h0000_0000})
    end_test("reset");
    apb_xfer(1'b1, `PT_OFF_CTRL, 32'h0000_0000);
    touch_sensed <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHECK(pen_wire, 1'b1)
    apb_xfer(1'b1, `PT_OFF_CTRL, `PT_CTRL_RESET);
    `WAIT_UNTIL(pen_touch_request_oe === 1'b1, 8)
    `CHECK(pen_wire, 1'b0)
    `CHECK(pen_touch_request_n, 1'b0)
    `CHECK(irq, 1'b0)
    apb_xfer(1'b1, `PT_OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHECK(irq, 1'b1)
    apb_xfer(1'b0, `PT_OFF_STATUS, 32'h0);
    `CHECK(rd, 32'h0000_0001)
    repeat (2) @(posedge pclk);
    `CHECK(irq, 1'b0)
    end_test("touch and interrupt");
    send_word(8'h82);
    `WAIT_UNTIL(fall_count === 4'h4, 100)
    `CHECK(pen_wire, 1'b0)
    `WAIT_UNTIL(pen_touch_request_oe === 1'b0, 6)
    `CHECK(pen_wire, 1'b1)
    `WAIT_UNTIL(fall_count === 4'h7, 100)
    `CHECK(power_down_select_bits, `PT_PD_RESET)
    `WAIT_UNTIL(busy === 1'b0, 40)
    repeat (20) @(posedge pclk);
    `CHECK(pen_wire, 1'b1)
    `CHECK(power_down_select_bits, 2'h2)
    conv_done();
    `WAIT_UNTIL(pen_touch_request_oe === 1'b1, 6)
    `CHECK(pen_wire, 1'b0)
    end_test("host word");
    send_word(8'h83);
    `WAIT_UNTIL(busy === 1'b0, 120)
    repeat (10) @(posedge pclk);
    conv_done();
    repeat (10) @(posedge pclk);
    `CHECK(pen_wire, 1'b1)
    apb_xfer(1'b0, `PT_OFF_STATE, 32'h0);
    `CHECK(rd, 32'h0000_00C0)
    end_test("always powered");
    touch_sensed <= 1'b0;
    send_word(8'h80);
    `WAIT_UNTIL(busy === 1'b0, 120)
    repeat (10) @(posedge pclk);
    send_word(8'h80);
    `WAIT_UNTIL(fall_count === 4'h2, 40)
    touch_sensed <= 1'b1;
    conv_done();
    bad = 1'b0;
    repeat (120) begin
      @(posedge pclk);
      bad = bad | pen_touch_request_oe;
    end
    `CHECK(bad, 1'b0)
    conv_done();
    `WAIT_UNTIL(pen_touch_request_oe === 1'b1, 6)
    `CHECK(pen_wire, 1'b0)
    apb_xfer(1'b0, `PT_OFF_STATUS, 32'h0);
    `CHECK(rd, 32'h0000_000F)
    apb_xfer(1'b0, `PT_OFF_STATUS, 32'h0);
    `CHECK(rd, 32'h0000_0000)
    end_test("overlapped words");
    complete_run();
  end
endmodule // pen_touch_request_tb
